// ### inc/tbg_pkg.sv
// Purpose: shared constants for the two-pin gpio port
// Assumes: 8-bit special-function register space, 9-bit addresses
// Notes:   register offsets are byte addresses on the core's register port
`default_nettype none
package tbg_pkg;
  localparam int          TBG_ADDR_W          = 9;
  localparam int          TBG_DATA_W          = 8;
  localparam int          TBG_PINS            = 2;
  localparam logic [8:0]  TBG_DATA_OFS        = 9'h092;
  localparam logic [8:0]  TBG_DIR_OFS         = 9'h093;
  localparam logic [8:0]  TBG_PULLDN_OFS      = 9'h098;
  localparam logic [8:0]  TBG_PULLUP_OFS      = 9'h099;
  localparam logic [8:0]  TBG_ANSEL_OFS       = 9'h112;
  localparam logic [1:0]  TBG_DIR_RST         = 2'h3;
  localparam logic [1:0]  TBG_PULL_RST        = 2'h0;
  localparam logic [1:0]  TBG_ANSEL_RST       = 2'h0;
  localparam logic [1:0]  TBG_LATCH_RST       = 2'h0;
  localparam logic [5:0]  TBG_UNUSED_ZERO     = 6'h00;
  localparam int          TBG_ANALOG_CH_BASE  = 16;
  typedef enum logic [2:0] {
    TBG_SEL_NONE, TBG_SEL_DATA, TBG_SEL_DIR, TBG_SEL_PULLDN, TBG_SEL_PULLUP, TBG_SEL_ANSEL
  } tbg_sel_t;
endpackage : tbg_pkg
`default_nettype wire

// ### rtl/tbg_sync.sv
// Purpose: two-flop synchroniser for the pin levels
// Assumes: pins are asynchronous to sys_clk_in
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module tbg_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_b_in,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // two flip-flop stages
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule : tbg_sync
`default_nettype wire

// ### rtl/tbg_port.sv
// Purpose: two-pin bidirectional gpio port with pull and analog select control
// Assumes: core register port with one-cycle write strobe and combinational read decode
// Notes:   read data is registered, so it appears one cycle after the read strobe
//
// Contract
// - two bidirectional pins; direction one means input, zero means output
// - data read returns sampled pins for digital inputs only; data write updates the output latch
// - every single-bit data write is read-modify-write from current pin read value; byte writes take the write data whole
// - direction keeps steering the driver even when pin is analog
// - analog-selected pins read zero on every digital data read
// - direction bits 1 and 0 reset to one, both pins inputs
// - per-pin weak pull-up enable, forced off while pin is output
// - per-pin weak pull-down enable, forced off while pin is output
// - analog-select bits 1,0 map to analog channels 17,16; one selects analog
// - analog select leaves digital output path and driver untouched
// - output pin reads back the output latch, not the line level
// - registers accept whole-byte writes and single-bit set or clear
`timescale 1ns/1ps
`default_nettype none
module tbg_port
  import tbg_pkg::*;
#(
  parameter int PINS = TBG_PINS
) (
  // clock and reset
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_b_in,
  // core register port
  input  wire logic [TBG_ADDR_W-1:0] reg_addr_in,
  input  wire logic                  reg_wr_in,
  input  wire logic                  reg_rd_in,
  input  wire logic [TBG_DATA_W-1:0] reg_wdata_in,
  input  wire logic                  reg_bit_op_in,
  input  wire logic [2:0]            reg_bit_sel_in,
  input  wire logic                  reg_bit_val_in,
  output logic      [TBG_DATA_W-1:0] reg_rdata_out,
  // pins
  input  wire logic [PINS-1:0]       pin_level_in,
  output logic      [PINS-1:0]       pin_drive_out,
  output logic      [PINS-1:0]       pin_drive_en_out,
  output logic      [PINS-1:0]       pin_pullup_en_out,
  output logic      [PINS-1:0]       pin_pulldown_en_out,
  // analog front end
  output logic      [PINS-1:0]       analog_sel_out
);
  // register select decode
  function automatic tbg_sel_t tbg_decode(input logic [TBG_ADDR_W-1:0] a);
    unique case (a)
      TBG_DATA_OFS:   tbg_decode = TBG_SEL_DATA;
      TBG_DIR_OFS:    tbg_decode = TBG_SEL_DIR;
      TBG_PULLDN_OFS: tbg_decode = TBG_SEL_PULLDN;
      TBG_PULLUP_OFS: tbg_decode = TBG_SEL_PULLUP;
      TBG_ANSEL_OFS:  tbg_decode = TBG_SEL_ANSEL;
      default:        tbg_decode = TBG_SEL_NONE;
    endcase
  endfunction : tbg_decode

  logic [PINS-1:0]       pin_sync;
  logic [PINS-1:0]       latch_reg,  latch_next;
  logic [PINS-1:0]       dir_reg,    dir_next;
  logic [PINS-1:0]       pullup_reg, pullup_next;
  logic [PINS-1:0]       pulldn_reg, pulldn_next;
  logic [PINS-1:0]       ansel_reg,  ansel_next;
  logic [TBG_DATA_W-1:0] rdata_reg,  rdata_next;
  logic [PINS-1:0]       drive_reg,  drive_next;
  logic [PINS-1:0]       drv_en_reg, drv_en_next;
  logic [PINS-1:0]       pu_reg,     pu_next;
  logic [PINS-1:0]       pd_reg,     pd_next;
  logic [PINS-1:0]       port_view;
  logic [TBG_DATA_W-1:0] cur_val;
  logic [TBG_DATA_W-1:0] new_val;
  tbg_sel_t              sel;

  // pin levels pass two flops before use
  tbg_sync #(.WIDTH(PINS)) u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .async_in   (pin_level_in),
    .sync_out   (pin_sync)
  );

  // digital view of the port as seen by a read
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      if (ansel_reg[i])
        port_view[i] = 1'b0;
      else if (!dir_reg[i])
        port_view[i] = latch_reg[i];
      else
        port_view[i] = pin_sync[i];
    end
  end

  // current contents of the addressed register, upper bits zero
  always_comb begin
    sel     = tbg_decode(reg_addr_in);
    cur_val = '0;
    unique case (sel)
      TBG_SEL_DATA:   cur_val = {TBG_UNUSED_ZERO, port_view};
      TBG_SEL_DIR:    cur_val = {TBG_UNUSED_ZERO, dir_reg};
      TBG_SEL_PULLDN: cur_val = {TBG_UNUSED_ZERO, pulldn_reg};
      TBG_SEL_PULLUP: cur_val = {TBG_UNUSED_ZERO, pullup_reg};
      TBG_SEL_ANSEL:  cur_val = {TBG_UNUSED_ZERO, ansel_reg};
      TBG_SEL_NONE:   cur_val = '0;
    endcase
  end

  // register write path
  always_comb begin
    latch_next  = latch_reg;
    dir_next    = dir_reg;
    pullup_next = pullup_reg;
    pulldn_next = pulldn_reg;
    ansel_next  = ansel_reg;
    new_val = cur_val;
    if (reg_bit_op_in)
      new_val[reg_bit_sel_in] = reg_bit_val_in;
    else
      new_val = reg_wdata_in;
    if (reg_wr_in) begin
      unique case (sel)
        TBG_SEL_DATA:   latch_next  = new_val[PINS-1:0];
        TBG_SEL_DIR:    dir_next    = new_val[PINS-1:0];
        TBG_SEL_PULLDN: pulldn_next = new_val[PINS-1:0];
        TBG_SEL_PULLUP: pullup_next = new_val[PINS-1:0];
        TBG_SEL_ANSEL:  ansel_next  = new_val[PINS-1:0];
        TBG_SEL_NONE:   ;
      endcase
    end
  end

  // pin control and read data next values
  always_comb begin
    drive_next  = latch_next;
    drv_en_next = ~dir_next;
    pu_next     = pullup_next & dir_next;
    pd_next     = pulldn_next & dir_next;
    rdata_next  = reg_rd_in ? cur_val : rdata_reg;
  end

  // state registers
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      latch_reg  <= TBG_LATCH_RST;
      dir_reg    <= TBG_DIR_RST;
      pullup_reg <= TBG_PULL_RST;
      pulldn_reg <= TBG_PULL_RST;
      ansel_reg  <= TBG_ANSEL_RST;
      rdata_reg  <= '0;
      drive_reg  <= TBG_LATCH_RST;
      drv_en_reg <= ~TBG_DIR_RST;
      pu_reg     <= TBG_PULL_RST;
      pd_reg     <= TBG_PULL_RST;
    end else begin
      latch_reg  <= latch_next;
      dir_reg    <= dir_next;
      pullup_reg <= pullup_next;
      pulldn_reg <= pulldn_next;
      ansel_reg  <= ansel_next;
      rdata_reg  <= rdata_next;
      drive_reg  <= drive_next;
      drv_en_reg <= drv_en_next;
      pu_reg     <= pu_next;
      pd_reg     <= pd_next;
    end
  end

  assign reg_rdata_out       = rdata_reg;
  assign pin_drive_out       = drive_reg;
  assign pin_drive_en_out    = drv_en_reg;
  assign pin_pullup_en_out   = pu_reg;
  assign pin_pulldown_en_out = pd_reg;
  assign analog_sel_out      = ansel_reg;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence data_wr_s;
    reg_wr_in && sel == TBG_SEL_DATA && !reg_bit_op_in;
  endsequence

  data_write_a: assert property (data_wr_s |=> pin_drive_out == $past(reg_wdata_in[PINS-1:0]))
    else $error("data write did not reach the pin driver");
  drive_dir_a: assert property (##1 pin_drive_en_out == ~dir_reg)
    else $error("driver enable disagrees with direction");
  pullup_gate_a: assert property ((pin_pullup_en_out & ~dir_reg) == '0)
    else $error("pull-up enabled on output pin");
  pulldn_gate_a: assert property (##1 (pin_pulldown_en_out & ~dir_reg) == '0)
    else $error("pull-down enabled on output pin");
  analog_zero_a: assert property (reg_rd_in && sel == TBG_SEL_DATA |=> (reg_rdata_out[PINS-1:0] & $past(ansel_reg)) == '0)
    else $error("analog pin read nonzero");
  out_readback_a: assert property (reg_rd_in && sel == TBG_SEL_DATA && ansel_reg == '0 && dir_reg == '0
                                   |=> reg_rdata_out[PINS-1:0] == $past(latch_reg))
    else $error("output pin did not read back the latch");
  upper_zero_a: assert property (reg_rdata_out[TBG_DATA_W-1:PINS] == TBG_UNUSED_ZERO)
    else $error("unused read bits nonzero");
  bit_rmw_a: assert property (reg_wr_in && reg_bit_op_in && sel == TBG_SEL_DIR && reg_bit_sel_in == 3'h0
                              |=> dir_reg[1] == $past(dir_reg[1]) && dir_reg[0] == $past(reg_bit_val_in))
    else $error("bit write disturbed other bits");
  analog_drive_a: assert property (##1 ansel_reg[0] && !dir_reg[0] |-> pin_drive_en_out[0])
    else $error("analog select disabled the output driver");
endmodule : tbg_port
`default_nettype wire

// ### testbench/tbg_board.sv
// Purpose: board model standing on the two port pins
// Assumes: a board source is stronger than the weak pulls, weaker than the port driver
// Notes:   an undriven pin with no pull toggles every cycle so it never looks settled
`timescale 1ns/1ps
`default_nettype none
module tbg_board (
  // clock
  input  wire logic       sys_clk_in,
  // port side
  input  wire logic [1:0] drive_in,
  input  wire logic [1:0] drive_en_in,
  input  wire logic [1:0] pullup_en_in,
  input  wire logic [1:0] pulldown_en_in,
  // board source
  input  wire logic [1:0] ext_en_in,
  input  wire logic [1:0] ext_val_in,
  output logic      [1:0] pin_level_out
);
  logic [1:0] float_reg = 2'h0;
  // floating pattern changes every cycle
  always @(posedge sys_clk_in) float_reg <= ~float_reg;
  // wire level: port driver first, then board source, then weak pulls
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (drive_en_in[i]) pin_level_out[i] = drive_in[i];
      else if (ext_en_in[i]) pin_level_out[i] = ext_val_in[i];
      else if (pullup_en_in[i]) pin_level_out[i] = 1'h1;
      else if (pulldown_en_in[i]) pin_level_out[i] = 1'h0;
      else pin_level_out[i] = float_reg[i];
    end
  end
endmodule : tbg_board
`default_nettype wire

// ### testbench/tb_top.sv
// Purpose: self-checking bench for the two-pin port
// Assumes: bench drives on the falling edge and samples settled values
// Notes:   random configurations from a fixed seed plus reset and refusal corners
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tbg_pkg::*;
  logic                  sys_clk_in = 1'h0;
  logic                  rst_b_in   = 1'h0;
  logic [TBG_ADDR_W-1:0] reg_addr   = '0;
  logic                  reg_wr = 1'h0, reg_rd = 1'h0, bit_op = 1'h0, bit_val = 1'h0;
  logic [2:0]            bit_sel = 3'h0;
  logic [7:0]            wdata   = 8'h00;
  logic [7:0]            rdata;
  logic [1:0]            pin_lvl, drv, drv_en, pu_en, pd_en, asel, lat, view;
  logic [1:0]            ext_en = 2'h3, ext_val = 2'h0;
  logic [1:0]            cfg [4];
  logic [8:0]            ofs [4] = '{TBG_DIR_OFS, TBG_PULLUP_OFS, TBG_PULLDN_OFS, TBG_ANSEL_OFS};
  int                    mismatches = 0;
  int                    cmp_count  = 0;
  // core clock, 4 ns period
  always #2 sys_clk_in = ~sys_clk_in;
  tbg_port i_dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(wdata), .reg_bit_op_in(bit_op),
    .reg_bit_sel_in(bit_sel), .reg_bit_val_in(bit_val), .reg_rdata_out(rdata), .pin_level_in(pin_lvl),
    .pin_drive_out(drv), .pin_drive_en_out(drv_en), .pin_pullup_en_out(pu_en),
    .pin_pulldown_en_out(pd_en), .analog_sel_out(asel));
  tbg_board i_board (.sys_clk_in(sys_clk_in), .drive_in(drv), .drive_en_in(drv_en),
    .pullup_en_in(pu_en), .pulldown_en_in(pd_en), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .pin_level_out(pin_lvl));
  // compare one value and count it
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // one write strobe: whole byte, or single-bit set or clear when op is high
  task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic op, input logic [2:0] s,
                    input logic v);
    @(negedge sys_clk_in);
    reg_addr = a;
    wdata    = d;
    bit_op   = op;
    bit_sel  = s;
    bit_val  = v;
    reg_wr   = 1'h1;
    @(negedge sys_clk_in);
    reg_wr   = 1'h0;
  endtask : wr
  // one read strobe; registered data is taken a cycle later
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(negedge sys_clk_in);
    reg_addr = a;
    reg_rd   = 1'h1;
    @(negedge sys_clk_in);
    reg_rd   = 1'h0;
    @(negedge sys_clk_in);
    d = rdata;
  endtask : rd
  // digital view of the port: analog reads 0, output reads latch, input reads line
  function automatic logic [1:0] port_view(input logic [1:0] l);
    return ~cfg[3] & ((cfg[0] & ext_val) | (~cfg[0] & l));
  endfunction : port_view
  // pin control outputs against the register model
  task automatic check_pins();
    check("drive", {6'h00, drv}, {6'h00, lat});
    check("drive_en", {6'h00, drv_en}, {6'h00, ~cfg[0]});
    check("pullup", {6'h00, pu_en}, {6'h00, cfg[1] & cfg[0]});
    check("pulldown", {6'h00, pd_en}, {6'h00, cfg[2] & cfg[0]});
    check("analog", {6'h00, asel}, {6'h00, cfg[3]});
  endtask : check_pins
  // verdict and end of run
  task automatic end_of_test();
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // watchdog against a hung handshake
  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end
  // main sequence
  initial begin
    logic [7:0] r;
    logic [2:0] s;
    void'($urandom(71618));
    repeat (3) @(negedge sys_clk_in);
    rst_b_in = 1'h1;
    cfg = '{2'h3, 2'h0, 2'h0, 2'h0};
    lat = 2'h0;
    check_pins();
    // reset values, then upper bits refused on the direction, pull and analog-select registers
    for (int k = 0; k < 4; k++) begin
      rd(ofs[k], r);
      check("reset_val", r, {6'h00, cfg[k]});
      wr(ofs[k], 8'hff, 1'h0, 3'h0, 1'h0);
      rd(ofs[k], r);
      check("upper_bits", r, 8'h03);
      cfg[k] = 2'h3;
    end
    // single-bit clear of direction 1, then an ignored bit op above bit 1
    wr(TBG_DIR_OFS, 8'h00, 1'h1, 3'h1, 1'h0);
    wr(TBG_DIR_OFS, 8'h00, 1'h1, 3'h5, 1'h1);
    cfg[0] = 2'h1;
    rd(TBG_DIR_OFS, r);
    check("dir_bit_op", r, 8'h01);
    check_pins();
    wr(9'h0a0, 8'hff, 1'h0, 3'h0, 1'h0);
    rd(9'h0a0, r);
    check("unmapped", r, 8'h00);
    ext_val = 2'h3;
    wr(TBG_DIR_OFS, 8'h00, 1'h1, 3'h0, 1'h1);
    wr(TBG_DIR_OFS, 8'h00, 1'h1, 3'h1, 1'h1);
    cfg[0] = 2'h3;
    rd(TBG_DIR_OFS, r);
    check("dir_bit_set", r, 8'h03);
    rd(TBG_DATA_OFS, r);
    check("analog_input", r, 8'h00);
    // pins left to the weak pulls alone
    ext_en = 2'h0;
    wr(TBG_ANSEL_OFS, 8'h00, 1'h0, 3'h0, 1'h0);
    wr(TBG_PULLDN_OFS, 8'h00, 1'h0, 3'h0, 1'h0);
    cfg[3] = 2'h0;
    cfg[2] = 2'h0;
    repeat (3) @(negedge sys_clk_in);
    rd(TBG_DATA_OFS, r);
    check("pulled_up", r, 8'h03);
    wr(TBG_PULLUP_OFS, 8'h00, 1'h0, 3'h0, 1'h0);
    wr(TBG_PULLDN_OFS, 8'h03, 1'h0, 3'h0, 1'h0);
    cfg[1] = 2'h0;
    cfg[2] = 2'h3;
    repeat (3) @(negedge sys_clk_in);
    rd(TBG_DATA_OFS, r);
    check("pulled_down", r, 8'h00);
    check_pins();
    ext_en = 2'h3;
    // random configurations, byte and bit writes to data
    repeat (40) begin
      ext_val = 2'($urandom);
      for (int k = 0; k < 4; k++) begin
        r = 8'($urandom);
        cfg[k] = r[1:0];
        wr(ofs[k], r, 1'h0, 3'h0, 1'h0);
      end
      r = 8'($urandom);
      lat = r[1:0];
      wr(TBG_DATA_OFS, r, 1'h0, 3'h0, 1'h0);
      repeat (3) @(negedge sys_clk_in);
      s = 3'($urandom % 2);
      view = port_view(lat);
      view[s[0]] = r[7];
      wr(TBG_DATA_OFS, 8'h00, 1'h1, s, r[7]);
      lat = view;
      repeat (3) @(negedge sys_clk_in);
      check_pins();
      rd(TBG_DATA_OFS, r);
      check("data_read", r, {6'h00, port_view(lat)});
      rd(ofs[s[0]], r);
      check("cfg_read", r, {6'h00, cfg[s[0]]});
    end
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
